// File: verilog/acr_defines.vh
/*
 amplifier control register bank: offsets, field positions, reset values, codes.
 assumes inclusion by bare name from the design files.
*/
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH
`define ACR_ADDR_ID 8'h00
`define ACR_ADDR_PWR 8'h01
`define ACR_ADDR_DIG 8'h02
`define ACR_ADDR_VOLCFG 8'h03
`define ACR_ADDR_VOLL 8'h04
`define ACR_ADDR_VOLR 8'h05
`define ACR_ADDR_ANA 8'h06
`define ACR_ADDR_RSV7 8'h07
`define ACR_ADDR_FAULT 8'h08
`define ACR_ADDR_RSVLO 8'h09
`define ACR_ADDR_RSVHI 8'h0f
`define ACR_ADDR_CLIPM 8'h10
`define ACR_ADDR_CLIPL 8'h11
`define ACR_RST_PWR 8'hfd
`define ACR_RST_DIG 8'h14
`define ACR_RST_VOLCFG 8'h80
`define ACR_RST_VOL 8'hcf
`define ACR_RST_ANA 8'h51
`define ACR_RST_RSV7 8'h00
`define ACR_RST_FAULT 8'h00
`define ACR_RST_CLIPM 8'hff
`define ACR_RST_CLIPL 8'hfc
`define ACR_PWR_SLEEP 1
`define ACR_PWR_SHDN_N 0
`define ACR_DIG_HPF 7
`define ACR_DIG_RSV 6
`define ACR_DIG_BOOST_HI 5
`define ACR_DIG_BOOST_LO 4
`define ACR_DIG_SPEED 3
`define ACR_DIG_FMT_HI 2
`define ACR_DIG_FMT_LO 0
`define ACR_FMT_MAX 3'h5
`define ACR_SLAVE_UPPER 6'h36
`define ACR_FILTER_LEN 3
`endif

// File: verilog/acr_line_filter.v
/*
 glitch filter for one bus line: output follows input after a stable run.
 assumes input already synchronous to clk.
*/
`timescale 1ns/1ps
`include "acr_defines.vh"
module acr_line_filter (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// line
	input wire lineIn,
	output reg lineOut
);
	reg [1:0] stableCount;
	always @(posedge clk) begin
		if (sys_rst) begin
			lineOut <= 1'b1;
			stableCount <= 2'h0;
		end else if (lineIn == lineOut) begin
			stableCount <= 2'h0;
		end else if (stableCount == 2'd`ACR_FILTER_LEN - 2'd1) begin
			lineOut <= lineIn;
			stableCount <= 2'h0;
		end else begin
			stableCount <= stableCount + 2'h1;
		end
	end
endmodule

// File: verilog/acr_edge_detect.v
/*
 edge detector for the filtered bus lines: scl edges and start/stop.
 assumes filtered inputs.
*/
`timescale 1ns/1ps
module acr_edge_detect (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// filtered lines
	input wire sclIn,
	input wire sdaIn,
	// events
	output wire sclRise,
	output wire sclFall,
	output wire startSeen,
	output wire stopSeen
);
	reg sclLast;
	reg sdaLast;
	always @(posedge clk) begin
		if (sys_rst) begin
			sclLast <= 1'b1;
			sdaLast <= 1'b1;
		end else begin
			sclLast <= sclIn;
			sdaLast <= sdaIn;
		end
	end
	assign sclRise = sclIn & ~sclLast;
	assign sclFall = ~sclIn & sclLast;
	assign startSeen = sclIn & sclLast & sdaLast & ~sdaIn;
	assign stopSeen = sclIn & sclLast & ~sdaLast & sdaIn;
endmodule

// File: verilog/acr_register_bank.v
/*
 amplifier control register bank behind an i2c slave port.
 assumes scl/sda and the sleep/address pin are synchronous to clk; sys_rst marks power-up.
*/
// Behaviour
// - clip threshold upper bits in power bits 7:2
// - 20-bit threshold from three register fields
// - sleep bit disables power stage only
// - shutdown bit zero powers amplifier down
// - bit 7 bypasses highpass filter
// - bits 5:4 select digital boost
// - bit 3 selects single or double speed
// - bits 2:0 select serial input format
// - read-only identification byte at 0x00
// - address pin sampled once as bit
// - address, register, data each acknowledged
`timescale 1ns/1ps
`include "acr_defines.vh"
module acr_register_bank #(
	parameter [7:0] ID_CODE = 8'h5a // arbitrary value
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// i2c pins
	input wire sclIn,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOe,
	// strap
	input wire sleep_addr_pin,
	// controls to the amplifier
	output reg [19:0] clip_threshold,
	output reg amp_sleep_bit,
	output reg amp_shutdown_n,
	output reg highpass_bypass,
	output reg [1:0] boostSel,
	output reg rate_speed_select,
	output reg [2:0] inputFormat,
	output reg [7:0] volumeConfig,
	output reg [7:0] volumeLeft,
	output reg [7:0] volumeRight,
	output reg [7:0] analogControl,
	output reg [7:0] faultConfig
);
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_DEV = 6'h02;
	localparam [5:0] ST_ACK = 6'h04;
	localparam [5:0] ST_RX = 6'h08;
	localparam [5:0] ST_TX = 6'h10;
	localparam [5:0] ST_MACK = 6'h20;

	wire sclF;
	wire sdaF;
	wire sclRise;
	wire sclFall;
	wire startSeen;
	wire stopSeen;

	// one filter per bus line, equal delay keeps start/stop order
	wire [1:0] rawLines = {sclIn, sdaIn};
	wire [1:0] cleanLines;
	genvar lineIdx;
	generate
		for (lineIdx = 0; lineIdx < 2; lineIdx = lineIdx + 1) begin : lineFilt
			acr_line_filter filt (
				.clk(clk),
				.sys_rst(sys_rst),
				.lineIn(rawLines[lineIdx]),
				.lineOut(cleanLines[lineIdx])
			);
		end
	endgenerate
	assign sclF = cleanLines[1];
	assign sdaF = cleanLines[0];
	acr_edge_detect edges (
		.clk(clk),
		.sys_rst(sys_rst),
		.sclIn(sclF),
		.sdaIn(sdaF),
		.sclRise(sclRise),
		.sclFall(sclFall),
		.startSeen(startSeen),
		.stopSeen(stopSeen)
	);

	// registers
	reg [7:0] regPower;
	reg [7:0] regDigital;
	reg [7:0] regReserved7;
	reg [7:0] regClipMid;
	reg [7:0] regClipLow;
	reg addrBit;
	reg strapTaken;

	// protocol state
	reg [5:0] state;
	reg [2:0] bitCount;
	reg [7:0] shiftReg;
	reg [7:0] regPtr;
	reg haveRegAddr;
	reg readMode;
	reg ackPending;
	reg [7:0] readData;
	reg writeStrobe;
	reg [7:0] writeData;

	wire [6:0] slaveAddr = {`ACR_SLAVE_UPPER, addrBit};
	wire [7:0] nextShift = {shiftReg[6:0], sdaF};

	// register read mux
	always @* begin
		case (regPtr)
			`ACR_ADDR_ID: readData = ID_CODE;
			`ACR_ADDR_PWR: readData = regPower;
			`ACR_ADDR_DIG: readData = regDigital;
			`ACR_ADDR_VOLCFG: readData = volumeConfig;
			`ACR_ADDR_VOLL: readData = volumeLeft;
			`ACR_ADDR_VOLR: readData = volumeRight;
			`ACR_ADDR_ANA: readData = analogControl;
			`ACR_ADDR_RSV7: readData = regReserved7;
			`ACR_ADDR_FAULT: readData = faultConfig;
			`ACR_ADDR_CLIPM: readData = regClipMid;
			`ACR_ADDR_CLIPL: readData = regClipLow;
			default: readData = 8'h00;
		endcase
	end

	// strap capture once after reset release
	always @(posedge clk) begin
		if (sys_rst) begin
			addrBit <= 1'b0;
			strapTaken <= 1'b0;
		end else if (!strapTaken) begin
			addrBit <= sleep_addr_pin;
			strapTaken <= 1'b1;
		end
	end

	// i2c byte engine
	always @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			bitCount <= 3'h0;
			shiftReg <= 8'h00;
			regPtr <= 8'h00;
			haveRegAddr <= 1'b0;
			readMode <= 1'b0;
			ackPending <= 1'b0;
			sdaOut <= 1'b1;
			sdaOe <= 1'b0;
			writeStrobe <= 1'b0;
			writeData <= 8'h00;
		end else begin
			writeStrobe <= 1'b0;
			if (startSeen) begin
				state <= ST_DEV;
				bitCount <= 3'h0;
				haveRegAddr <= 1'b0;
				sdaOe <= 1'b0;
			end else if (stopSeen) begin
				state <= ST_IDLE;
				sdaOe <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						sdaOe <= 1'b0;
					end
					ST_DEV: begin
						if (sclRise) begin
							shiftReg <= nextShift;
							bitCount <= bitCount + 3'h1;
							if (bitCount == 3'h7) begin
								if (nextShift[7:1] == slaveAddr) begin
									readMode <= nextShift[0];
									state <= ST_ACK;
								end else begin
									state <= ST_IDLE;
								end
							end
						end
					end
					ST_ACK: begin
						// drive ack low through the ninth clock
						if (sclFall && !ackPending) begin
							sdaOut <= 1'b0;
							sdaOe <= 1'b1;
							ackPending <= 1'b1;
						end else if (sclFall && ackPending) begin
							ackPending <= 1'b0;
							bitCount <= 3'h0;
							if (readMode) begin
								state <= ST_TX;
								shiftReg <= {readData[6:0], 1'b0};
								sdaOut <= readData[7];
								sdaOe <= ~readData[7];
							end else begin
								state <= ST_RX;
								sdaOe <= 1'b0;
							end
						end
					end
					ST_RX: begin
						if (sclRise) begin
							shiftReg <= nextShift;
							bitCount <= bitCount + 3'h1;
							if (bitCount == 3'h7) begin
								state <= ST_ACK;
								if (!haveRegAddr) begin
									regPtr <= nextShift;
									haveRegAddr <= 1'b1;
								end else begin
									writeData <= nextShift;
									writeStrobe <= 1'b1;
								end
							end
						end
					end
					ST_TX: begin
						if (sclFall) begin
							bitCount <= bitCount + 3'h1;
							if (bitCount == 3'h7) begin
								state <= ST_MACK;
								sdaOe <= 1'b0;
							end else begin
								sdaOut <= shiftReg[7];
								sdaOe <= ~shiftReg[7];
								shiftReg <= {shiftReg[6:0], 1'b0};
							end
						end
					end
					ST_MACK: begin
						if (sclRise) begin
							if (sdaF) begin
								state <= ST_IDLE;
							end else begin
								regPtr <= regPtr + 8'h01;
								state <= ST_ACK;
								ackPending <= 1'b1;
							end
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
			if (writeStrobe) begin
				regPtr <= regPtr + 8'h01;
			end
		end
	end

	// register storage
	always @(posedge clk) begin
		if (sys_rst) begin
			regPower <= `ACR_RST_PWR;
			regDigital <= `ACR_RST_DIG;
			volumeConfig <= `ACR_RST_VOLCFG;
			volumeLeft <= `ACR_RST_VOL;
			volumeRight <= `ACR_RST_VOL;
			analogControl <= `ACR_RST_ANA;
			regReserved7 <= `ACR_RST_RSV7;
			faultConfig <= `ACR_RST_FAULT;
			regClipMid <= `ACR_RST_CLIPM;
			regClipLow <= `ACR_RST_CLIPL;
		end else if (writeStrobe) begin
			case (regPtr)
				`ACR_ADDR_PWR: regPower <= writeData;
				// reserved bit 6 kept at zero
				`ACR_ADDR_DIG: regDigital <= writeData & 8'hbf;
				`ACR_ADDR_VOLCFG: volumeConfig <= writeData;
				`ACR_ADDR_VOLL: volumeLeft <= writeData;
				`ACR_ADDR_VOLR: volumeRight <= writeData;
				`ACR_ADDR_ANA: analogControl <= writeData;
				`ACR_ADDR_RSV7: regReserved7 <= writeData;
				`ACR_ADDR_FAULT: faultConfig <= writeData;
				`ACR_ADDR_CLIPM: regClipMid <= writeData;
				`ACR_ADDR_CLIPL: regClipLow <= writeData;
				default: regReserved7 <= regReserved7;
			endcase
		end
	end

	// decoded controls, registered
	always @(posedge clk) begin
		if (sys_rst) begin
			clip_threshold <= 20'hffff0;
			amp_sleep_bit <= 1'b0;
			amp_shutdown_n <= 1'b0;
			highpass_bypass <= 1'b0;
			boostSel <= 2'h0;
			rate_speed_select <= 1'b0;
			inputFormat <= 3'h0;
		end else begin
			clip_threshold <= {regPower[7:2], regClipMid, regClipLow[7:2]};
			amp_sleep_bit <= regPower[`ACR_PWR_SLEEP];
			amp_shutdown_n <= regPower[`ACR_PWR_SHDN_N];
			highpass_bypass <= regDigital[`ACR_DIG_HPF];
			boostSel <= regDigital[`ACR_DIG_BOOST_HI:`ACR_DIG_BOOST_LO];
			rate_speed_select <= regDigital[`ACR_DIG_SPEED];
			inputFormat <= regDigital[`ACR_DIG_FMT_HI:`ACR_DIG_FMT_LO];
		end
	end
endmodule

// File: tb/acr_register_bank_sva.sv
/* port checker for the register bank.
 assumes scl phases of 12 clk from the host. */
`timescale 1ns/1ps
module acr_bank_chk (
	// clock, reset
	input wire clk,
	input wire sys_rst,
	// bus
	input wire sclIn,
	input wire sdaOut,
	input wire sdaOe,
	// controls
	input wire [19:0] clip_threshold,
	input wire amp_sleep_bit,
	input wire amp_shutdown_n,
	input wire [1:0] boostSel,
	input wire [2:0] inputFormat
);
	reg [3:0] rstHist = 4'hf;
	always @(posedge clk)
		rstHist <= {rstHist[2:0], sys_rst};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence ackHeld;
		sdaOe [*8];
	endsequence
	chk_pwr_default: assert property (
		$fell(sys_rst) |-> ##[1:2] (clip_threshold == 20'hfffff && amp_shutdown_n && !amp_sleep_bit))
		else $error("power defaults");
	chk_dig_default: assert property (
		$fell(sys_rst) |-> ##[1:2] (boostSel == 2'h1 && inputFormat == 3'h4))
		else $error("digital defaults");
	chk_oe_reset: assert property (disable iff (1'b0) sys_rst |=> !sdaOe) else $error("oe in reset");
	chk_ack_low: assert property (sdaOe |-> !sdaOut) else $error("driven high");
	chk_ack_hold: assert property ($rose(sdaOe) |-> ackHeld) else $error("short drive");
	chk_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn) else $error("sda moved");
	chk_fmt_legal: assert property (inputFormat <= 3'h5) else $error("format code");
	chk_ctl_quiet: assert property (
		rstHist == 4'h0 && ($changed(clip_threshold) || $changed(boostSel)) |-> sclIn)
		else $error("control moved off a write");
endmodule
bind acr_register_bank acr_bank_chk u_chk (.clk, .sys_rst, .sclIn, .sdaOut, .sdaOe,
	.clip_threshold, .amp_sleep_bit, .amp_shutdown_n, .boostSel, .inputFormat);

// File: tb/acr_host_model.sv
/* i2c host model for the register bank bus.
 assumes sda pulled up; the device pulls low through its enable. */
`timescale 1ns/1ps
module acr_host_model (
	// clock
	input wire clk,
	// bus
	input wire sdaWire,
	output reg scl = 1'b1,
	output reg sdaDrv = 1'b1,
	// read result
	output reg [7:0] rdByte = 8'h00,
	output reg rdValid = 1'b0
);
	reg r;
	integer i;
	task hc;
		repeat (12) @(negedge clk);
	endtask
	// one bit, sampled at the end of scl high
	task bitX(input b);
		sdaDrv = b;
		hc;
		scl = 1'b1;
		hc;
		r = sdaWire;
		scl = 1'b0;
	endtask
	// start or repeated start
	task start;
		sdaDrv = 1'b1;
		hc;
		scl = 1'b1;
		hc;
		sdaDrv = 1'b0;
		hc;
		scl = 1'b0;
	endtask
	task byteX(input [7:0] d, inout ok);
		for (i = 7; i >= 0; i--)
			bitX(d[i]);
		bitX(1'b1);
		ok = ok & !r;
	endtask
	task xfer(input rdMode, input [6:0] dev, input [7:0] ra, input [7:0] d, output ok);
		ok = 1'b1;
		start;
		byteX({dev, 1'b0}, ok);
		byteX(ra, ok);
		if (rdMode) begin
			start;
			byteX({dev, 1'b1}, ok);
			for (i = 7; i >= 0; i--) begin
				bitX(1'b1);
				rdByte[i] = r;
			end
			bitX(1'b1);
		end else
			byteX(d, ok);
		sdaDrv = 1'b0;
		hc;
		scl = 1'b1;
		hc;
		sdaDrv = 1'b1;
		hc;
		rdValid = rdMode;
		@(negedge clk);
		rdValid = 1'b0;
	endtask
	// stop: sda rises while scl is high
	task frameEnd;
		sdaDrv = 1'b0;
		hc;
		scl = 1'b1;
		hc;
		sdaDrv = 1'b1;
		hc;
	endtask
	// one read byte, the host's acknowledge bit, then a result strobe
	task getByte(input ackBit);
		for (i = 7; i >= 0; i--) begin
			bitX(1'b1);
			rdByte[i] = r;
		end
		bitX(ackBit);
		rdValid = 1'b1;
		@(negedge clk);
		rdValid = 1'b0;
	endtask
	// two bytes read in one frame, the first acknowledged by the host
	task rdPair(input [6:0] dev, input [7:0] ra, output ok);
		ok = 1'b1;
		start;
		byteX({dev, 1'b0}, ok);
		byteX(ra, ok);
		start;
		byteX({dev, 1'b1}, ok);
		getByte(1'b0);
		getByte(1'b1);
		frameEnd;
	endtask
	// two data bytes written in one frame
	task wrPair(input [6:0] dev, input [7:0] ra, input [7:0] d0, input [7:0] d1, output ok);
		ok = 1'b1;
		start;
		byteX({dev, 1'b0}, ok);
		byteX(ra, ok);
		byteX(d0, ok);
		byteX(d1, ok);
		frameEnd;
	endtask
endmodule

// File: tb/acr_register_bank_test.sv
/* self-checking bench for the register bank.
 assumes the host model on the bus. */
`timescale 1ns/1ps
module acr_register_bank_test;
	localparam [7:0] ID = 8'h3c; // arbitrary value
	localparam [87:0] RV = {ID, 80'hfd1480cfcf510000fffc};
	localparam [6:0] DEV = 7'h6d;
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg strap = 1'b1;
	reg ok;
	reg [7:0] pwr, dig, cm, cl;
	reg [7:0] expQ[$];
	reg [31:0] rs = 32'h6bb2188c;
	integer error_cnt = 0;
	integer checks_done = 0;
	integer cycles = 0;
	integer i;
	wire sclIn, sdaDrv, sdaOe, rdValid;
	wire sdaIn = (sdaOe === 1'b1) ? 1'b0 : sdaDrv;
	wire [7:0] rdByte;
	wire [7:0] flt;
	wire [31:0] raw;
	wire [19:0] clip;
	wire [1:0] pw;
	wire [6:0] dg;
	acr_register_bank #(.ID_CODE(ID)) dut (.clk(clk), .sys_rst(sys_rst), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe), .sleep_addr_pin(strap), .clip_threshold(clip),
		.amp_sleep_bit(pw[1]), .amp_shutdown_n(pw[0]), .highpass_bypass(dg[6]),
		.boostSel(dg[5:4]), .rate_speed_select(dg[3]), .inputFormat(dg[2:0]),
		.volumeConfig(raw[31:24]), .volumeLeft(raw[23:16]), .volumeRight(raw[15:8]),
		.analogControl(raw[7:0]), .faultConfig(flt));
	acr_host_model m (.clk(clk), .sdaWire(sdaIn), .scl(sclIn), .sdaDrv(sdaDrv),
		.rdByte(rdByte), .rdValid(rdValid));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rdValid === 1'b1)
			cmp(expQ.pop_front(), rdByte);
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			error_cnt++;
			conclude;
		end
	end
	task cmp(input [31:0] e, input [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	function [31:0] nextRand(input [31:0] s);
		reg [31:0] x;
		begin
			x = s ^ (s << 13);
			x = x ^ (x >> 17);
			nextRand = x ^ (x << 5);
		end
	endfunction
	task rdReg(input [7:0] ra, input [7:0] e);
		expQ.push_back(e);
		m.xfer(1'b1, DEV, ra, 8'h00, ok);
		cmp(1, ok);
	endtask
	task wrReg(input [7:0] ra, input [7:0] d);
		m.xfer(1'b0, DEV, ra, d, ok);
		cmp(1, ok);
	endtask
	task conclude;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		strap = 1'b0; // address must stay as latched
		cmp({clip, pw, dg}, {20'hfffff, 2'b01, 7'h14});
		cmp(raw, 32'h80cfcf51);
		cmp(flt, 8'h00);
		for (i = 0; i < 11; i++)
			rdReg(8'(i > 8 ? i + 7 : i), RV[8 * (10 - i) +: 8]);
		for (i = 0; i < 6; i++) begin
			rs = nextRand(rs);
			pwr = rs[7:0];
			dig = {rs[8], 1'b0, i[1:0], rs[9], i[2:0]};
			cm = rs[23:16];
			cl = rs[31:24];
			wrReg(8'h01, pwr);
			wrReg(8'h02, dig);
			wrReg(8'h10, cm);
			wrReg(8'h11, cl);
			cmp({clip, pw}, {pwr[7:2], cm, cl[7:2], pwr[1:0]});
			cmp(dg, {dig[7], dig[5:0]});
			rdReg(8'h01, pwr);
			rdReg(8'h02, dig);
		end
		expQ.push_back(cm);
		expQ.push_back(cl);
		m.rdPair(DEV, 8'h10, ok);
		cmp(1, ok);
		rs = nextRand(rs);
		m.wrPair(DEV, 8'h04, rs[7:0], rs[15:8], ok);
		cmp(1, ok);
		cmp(raw[23:8], {rs[7:0], rs[15:8]});
		m.xfer(1'b0, DEV, 8'h00, ~ID, ok);
		m.xfer(1'b0, DEV, 8'h09, 8'ha5, ok);
		m.xfer(1'b0, DEV, 8'h0f, 8'h5a, ok);
		m.xfer(1'b0, 7'h6c, 8'h01, 8'h00, ok);
		cmp(0, ok);
		rdReg(8'h00, ID);
		rdReg(8'h09, 8'h00);
		rdReg(8'h0f, 8'h00);
		rdReg(8'h01, pwr);
		sys_rst = 1'b1;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		cmp({clip, pw, dg}, {20'hfffff, 2'b01, 7'h14});
		m.xfer(1'b0, DEV, 8'h01, 8'h00, ok);
		cmp(0, ok);
		expQ.push_back(8'hfd);
		m.xfer(1'b1, 7'h6c, 8'h01, 8'h00, ok);
		cmp(1, ok);
		conclude;
	end
endmodule
